// file: icl_pkg.sv
// Purpose: constants for the interrupt control logic
// Assumes: 32-bit AXI4-Lite register access, byte addresses = 4 * index
// Notes: register indices kept as printed
package icl_pkg;
  // ==========================================================
  // register indices and byte addresses
  localparam logic [7:0] IDX_CTRL = 8'h0B;
  localparam logic [7:0] IDX_PFLAG = 8'h0C;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PEN = 8'h8C;
  localparam logic [7:0] IDX_PCSEL = 8'h96;
  localparam logic [7:0] IDX_CORE = 8'hF0;
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_PFLAG = {IDX_PFLAG, 2'b00};
  localparam logic [9:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
  localparam logic [9:0] ADDR_PEN = {IDX_PEN, 2'b00};
  localparam logic [9:0] ADDR_PCSEL = {IDX_PCSEL, 2'b00};
  localparam logic [9:0] ADDR_CORE = {IDX_CORE, 2'b00};
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PFLAG = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_PEN = 8'h00;
  localparam logic [5:0] RST_PCSEL = 6'h00;
  // ==========================================================
  // control/status fields
  localparam int B_GIE = 7;
  localparam int B_PERIPH_GROUP_ENABLE = 6;
  localparam int B_TIMER0_WRAP_ENABLE = 5;
  localparam int B_PINE = 4;
  localparam int B_PCE = 3;
  localparam int B_T0F = 2;
  localparam int B_PINF = 1;
  localparam int B_PCF = 0;
  localparam int B_EDGE = 6;
  // peripheral flag / enable fields
  localparam int B_EE = 7;
  localparam int B_AD = 6;
  localparam int B_CM = 3;
  localparam int B_T1 = 0;
  localparam logic [7:0] PERIPH_MASK = 8'hC9;
  // ==========================================================
  // vector and core timing
  localparam logic [12:0] SERVICE_VECTOR = 13'h0004;
  localparam logic [1:0] SYNC_LAT = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: icl_top.sv
// Purpose: interrupt control logic: flags, enables, core request, vector, wake
// Assumes: one instruction cycle per i_q_start pulse; events are one-cycle pulses
// Notes: watchdog and software context saving are outside this block
//
// Contract
// - seven sources: edge pin, timer0, port change, comparator, A/D, timer1, EEPROM.
// - global enable at control bit 7 gates the core request, not flags or wake; each source has own enable.
// - reset clears global enable; power reset zeroes control, others keep port flag; i_arst_n zeroes port flag too.
// - return-from-service sets global enable again.
// - on acceptance clear global enable, push return address, load vector 0004h.
// - edge-pin and port-change requests vector within three or four instruction cycles.
// - flags set on events whatever the enables.
// - instruction clearing global enable blocks next-cycle service; requests stay pending.
// - edge pin: rising if option bit 6 set, falling if clear; sets flag bit 1.
// - control bit 4 gates pin request; enabled pin event wakes from sleep.
// - pin flag may set during Q4 through Q1.
// - timer0 wrap sets control bit 2; control bit 5 enables it.
// - enabled port pin change sets bit 0; bit 3 gates; select register picks pins.
// - a change during port read at Q2 may be missed.
// - A/D done sets peripheral flag bit 6; enable bit 6 gates it.
// - peripheral flags EEPROM 7, A/D 6, comparator 3, timer1 0; enables alike.
// - hardware saves only return address; working registers left to software.
// - enabled request wakes sleep regardless of global enable.
module icl_top
  import icl_pkg::*;
#(
  parameter int PORT_W = 6
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_power_reset,
  input wire logic i_soft_reset,
  // pins
  input wire logic i_external_edge_pin,
  input wire logic [PORT_W-1:0] i_port_pins,
  // event pulses from peripherals
  input wire logic i_timer0_wrap,
  input wire logic i_comparator_change,
  input wire logic i_conversion_done,
  input wire logic i_timer1_wrap,
  input wire logic i_eeprom_write_done,
  // core sequencer
  input wire logic i_q_start,
  input wire logic i_return_from_service,
  input wire logic [12:0] i_return_pc,
  input wire logic i_sleeping,
  output logic o_core_request,
  output logic o_vector_load,
  output logic [12:0] o_vector_pc,
  output logic o_stack_push,
  output logic [12:0] o_stack_data,
  output logic o_wake,
  // axi4-lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // pin synchronisers
  logic pin_s1, pin_s2, pin_prev;
  logic [PORT_W-1:0] port_s1, port_s2, port_prev;
  logic next_pin_prev;
  logic [PORT_W-1:0] next_port_prev;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      port_s1 <= '0;
      port_s2 <= '0;
    end else begin
      pin_s1 <= i_external_edge_pin;
      pin_s2 <= pin_s1;
      port_s1 <= i_port_pins;
      port_s2 <= port_s1;
    end
  end

  // ==========================================================
  // registers
  logic [7:0] ctrl, pflag, option, pen;
  logic [PORT_W-1:0] pcsel;
  logic [7:0] next_ctrl, next_pflag, next_option, next_pen;
  logic [PORT_W-1:0] next_pcsel;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [9:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic req, next_req, vload, next_vload;
  logic [12:0] spc, next_spc;
  logic [1:0] age, next_age;

  logic pin_edge, port_change, do_write, accept;
  logic [7:0] wb;
  logic core_any, periph_any, wake_any;

  always_comb begin
    // edge polarity selected by option bit 6
    pin_edge = option[B_EDGE] ? (pin_s2 & ~pin_prev) : (~pin_s2 & pin_prev);
    port_change = |((port_s2 ^ port_prev) & pcsel);
    next_pin_prev = pin_s2;
    next_port_prev = port_s2;
  end

  // ==========================================================
  // axi write/read channel handling
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_hold && w_hold && !bvalid;
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
    end
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (do_write) begin
      next_bvalid = 1'b1;
      unique case (aw_addr)
        ADDR_CTRL, ADDR_PFLAG, ADDR_OPTION, ADDR_PEN, ADDR_PCSEL: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    wb = w_data[7:0];
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: next_rdata = {24'h000000, ctrl};
        ADDR_PFLAG: next_rdata = {24'h000000, pflag};
        ADDR_OPTION: next_rdata = {24'h000000, option};
        ADDR_PEN: next_rdata = {24'h000000, pen};
        ADDR_PCSEL: next_rdata = {{(32-PORT_W){1'b0}}, pcsel};
        ADDR_CORE: next_rdata = {15'h0000, age, req, vload, spc};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ==========================================================
  // flags, enables and service sequencing
  always_comb begin
    next_ctrl = ctrl;
    next_pflag = pflag;
    next_option = option;
    next_pen = pen;
    next_pcsel = pcsel;
    // software writes first; hardware sets below win over clears
    if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        ADDR_CTRL: next_ctrl = wb;
        ADDR_PFLAG: next_pflag = wb & PERIPH_MASK;
        ADDR_OPTION: next_option = wb;
        ADDR_PEN: next_pen = wb & PERIPH_MASK;
        ADDR_PCSEL: next_pcsel = wb[PORT_W-1:0];
        default: next_pcsel = pcsel;
      endcase
    end
    if (pin_edge) next_ctrl[B_PINF] = 1'b1;
    if (i_timer0_wrap) next_ctrl[B_T0F] = 1'b1;
    if (port_change) next_ctrl[B_PCF] = 1'b1;
    if (i_eeprom_write_done) next_pflag[B_EE] = 1'b1;
    if (i_conversion_done) next_pflag[B_AD] = 1'b1;
    if (i_comparator_change) next_pflag[B_CM] = 1'b1;
    if (i_timer1_wrap) next_pflag[B_T1] = 1'b1;
    if (i_return_from_service) next_ctrl[B_GIE] = 1'b1;
    core_any = (ctrl[B_TIMER0_WRAP_ENABLE] & ctrl[B_T0F]) | (ctrl[B_PINE] & ctrl[B_PINF])
             | (ctrl[B_PCE] & ctrl[B_PCF]);
    periph_any = ctrl[B_PERIPH_GROUP_ENABLE] & (|(pflag & pen));
    wake_any = core_any | periph_any;
    next_req = ctrl[B_GIE] & wake_any;
    // service taken only at an instruction boundary with enable still set
    accept = req && ctrl[B_GIE] && i_q_start && !i_sleeping;
    next_vload = accept;
    next_spc = spc;
    next_age = 2'h0;
    if (accept) begin
      next_ctrl[B_GIE] = 1'b0;
      next_spc = i_return_pc;
    end
    // pending core request of any source counted in instruction cycles
    if (req && i_q_start && age != 2'h3) next_age = age + 2'h1;
    else if (req) next_age = age;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= RST_CTRL;
      pflag <= RST_PFLAG;
      option <= RST_OPTION;
      pen <= RST_PEN;
      pcsel <= RST_PCSEL;
      pin_prev <= 1'b0;
      port_prev <= '0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      req <= 1'b0;
      vload <= 1'b0;
      spc <= '0;
      age <= '0;
    end else if (i_power_reset) begin
      ctrl <= RST_CTRL;
      pflag <= RST_PFLAG;
      option <= RST_OPTION;
      pen <= RST_PEN;
      pcsel <= RST_PCSEL;
      pin_prev <= pin_s2;
      port_prev <= port_s2;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      req <= 1'b0;
      vload <= 1'b0;
      spc <= '0;
      age <= '0;
    end else if (i_soft_reset) begin
      ctrl <= {7'h00, ctrl[B_PCF]};
      pflag <= RST_PFLAG;
      option <= RST_OPTION;
      pen <= RST_PEN;
      pcsel <= RST_PCSEL;
      pin_prev <= pin_s2;
      port_prev <= port_s2;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      req <= 1'b0;
      vload <= 1'b0;
      spc <= '0;
      age <= '0;
    end else begin
      ctrl <= next_ctrl;
      pflag <= next_pflag;
      option <= next_option;
      pen <= next_pen;
      pcsel <= next_pcsel;
      pin_prev <= next_pin_prev;
      port_prev <= next_port_prev;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      req <= next_req;
      vload <= next_vload;
      spc <= next_spc;
      age <= next_age;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    s_axi_awready = !aw_hold;
    s_axi_wready = !w_hold;
    s_axi_bvalid = bvalid;
    s_axi_bresp = bresp;
    s_axi_arready = !rvalid;
    s_axi_rvalid = rvalid;
    s_axi_rdata = rdata;
    s_axi_rresp = rresp;
    o_core_request = req;
    o_vector_load = vload;
    o_vector_pc = SERVICE_VECTOR;
    o_stack_push = vload;
    o_stack_data = spc;
    o_wake = wake_any;
  end

endmodule

// file: icl_monitor.sv
// Purpose: port checker for the interrupt control logic
// Assumes: bound to icl_top, one clock domain
// Notes: watches vector entry and bus answers
module icl_monitor
  import icl_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // core side
  input wire logic i_q_start,
  input wire logic i_sleeping,
  input wire logic [12:0] i_return_pc,
  input wire logic o_core_request,
  input wire logic o_vector_load,
  input wire logic [12:0] o_vector_pc,
  input wire logic o_stack_push,
  input wire logic [12:0] o_stack_data,
  // register bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // vector entry
  vec_one_pulse_a: assert property (o_vector_load |=> !o_vector_load)
    else $error("vector pulse too long");
  vec_cause_a: assert property (o_vector_load |-> $past(o_core_request && i_q_start))
    else $error("vector without request at boundary");
  sleep_block_a: assert property (i_sleeping |=> !o_vector_load)
    else $error("vector taken while sleeping");
  vec_addr_a: assert property (o_vector_pc == SERVICE_VECTOR)
    else $error("wrong vector address");
  push_pair_a: assert property (o_stack_push == o_vector_load)
    else $error("stack push not paired with vector");
  stack_save_a: assert property (o_vector_load |-> o_stack_data == $past(i_return_pc))
    else $error("wrong return address saved");
  req_drop_a: assert property (o_vector_load |=> !o_core_request)
    else $error("request stays after entry");
  // ==========================================================
  // register bus
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  vec_seen_c: cover property (o_vector_load);
  wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind icl_top icl_monitor u_icl_monitor (.i_sys_clk, .i_arst_n, .i_q_start, .i_sleeping,
  .i_return_pc, .o_core_request, .o_vector_load, .o_vector_pc, .o_stack_push, .o_stack_data,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_arvalid, .s_axi_arready);

// file: icl_core_model.sv
// Purpose: core sequencer model giving instruction boundaries
// Assumes: one instruction cycle is four clocks
// Notes: return address advances once per instruction
module icl_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // bench commands
  input wire logic i_ret_cmd,
  input wire logic i_sleep_cmd,
  // core side of the controller
  output logic o_q_start,
  output logic o_return_from_service,
  output logic [12:0] o_return_pc,
  output logic o_sleeping
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  // ==========================================================
  // sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
      o_q_start <= 1'b0;
      o_return_from_service <= 1'b0;
      o_return_pc <= 13'h0000;
      o_sleeping <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_q_start <= (phase == 2'h3);
      if (phase == 2'h3) o_return_pc <= o_return_pc + 13'h0001;
      o_return_from_service <= i_ret_cmd && !o_return_from_service;
      o_sleeping <= i_sleep_cmd;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the interrupt control logic
// Assumes: core model supplies instruction boundaries
// Notes: fixed seed, registers reached over axi4-lite
module tb_top
  import icl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_arst_n = 1'b0, pwr_rst = 1'b0, soft_rst = 1'b0, pin = 1'b0;
  logic ret_cmd = 1'b0, sleep_cmd = 1'b0, seen, q_start, ret, sleeping, wake, vload;
  logic [5:0] port = 6'h00;
  logic [4:0] ev = 5'h00;
  logic [7:0] rv;
  logic [12:0] rpc;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_rresp, s_axi_bresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  int error_cnt, n_compared, cyc;
  // ==========================================================
  // clock, models, timeout
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  icl_core_model u_icl_core_model (.i_clk(i_sys_clk), .i_rst_n(i_arst_n), .i_ret_cmd(ret_cmd),
    .i_sleep_cmd(sleep_cmd), .o_q_start(q_start), .o_return_from_service(ret),
    .o_return_pc(rpc), .o_sleeping(sleeping));
  icl_top u_icl_top (.i_sys_clk, .i_arst_n, .i_power_reset(pwr_rst), .i_soft_reset(soft_rst),
    .i_external_edge_pin(pin), .i_port_pins(port), .i_timer0_wrap(ev[0]),
    .i_comparator_change(ev[1]), .i_conversion_done(ev[2]), .i_timer1_wrap(ev[3]),
    .i_eeprom_write_done(ev[4]), .i_q_start(q_start), .i_return_from_service(ret),
    .i_return_pc(rpc), .i_sleeping(sleeping), .o_core_request(), .o_vector_load(vload),
    .o_vector_pc(), .o_stack_push(), .o_stack_data(), .o_wake(wake),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1));
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================================
  // checks and bus tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk_reg({30'h0, s_axi_bresp}, {30'h0, r}, "write response");
  endtask
  task automatic axi_rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] r = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk_reg(s_axi_rdata, {24'h0, e}, "read data");
    chk_reg({30'h0, s_axi_rresp}, {30'h0, r}, "read response");
  endtask
  task automatic ev_pulse(input int k);
    @(posedge i_sys_clk);
    ev[k] <= 1'b1;
    @(posedge i_sys_clk);
    ev <= 5'h00;
  endtask
  task automatic settle();
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic wait_vec(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_sys_clk);
      if (vload) seen = 1'b1;
    end
  endtask
  function automatic logic [7:0] ev_bit(input int k);
    logic [7:0] t [5] = '{8'h04, 8'h08, 8'h40, 8'h01, 8'h80};
    return t[k];
  endfunction
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(32'h9D84));
    repeat (3) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    axi_rd(ADDR_CTRL, RST_CTRL);
    axi_rd(ADDR_OPTION, RST_OPTION);
    axi_rd(ADDR_PEN, RST_PEN);
    axi_rd(10'h004, 8'h00, RESP_SLVERR);
    axi_rd(ADDR_CORE, 8'h00);
    axi_wr(10'h004, 8'h00, RESP_SLVERR);
    $display("reset values done");
    for (int k = 0; k < 5; k++) begin
      ev_pulse(k);
      axi_rd(k == 0 ? ADDR_CTRL : ADDR_PFLAG, ev_bit(k));
      axi_wr(k == 0 ? ADDR_CTRL : ADDR_PFLAG, 8'h00);
    end
    $display("event flags done");
    pin <= 1'b1;
    settle();
    axi_rd(ADDR_CTRL, 8'h02);
    axi_wr(ADDR_CTRL, 8'h00);
    axi_wr(ADDR_OPTION, 8'h00);
    pin <= 1'b0;
    settle();
    axi_rd(ADDR_CTRL, 8'h02);
    axi_wr(ADDR_CTRL, 8'h00);
    pin <= 1'b1;
    settle();
    axi_rd(ADDR_CTRL, 8'h00);
    axi_wr(ADDR_PCSEL, 8'h01);
    axi_rd(ADDR_PCSEL, 8'h01);
    port <= {5'($urandom_range(31, 1)), 1'b0};
    settle();
    axi_rd(ADDR_CTRL, 8'h00);
    port[0] <= 1'b1;
    settle();
    axi_rd(ADDR_CTRL, 8'h01);
    $display("pin and port done");
    axi_wr(ADDR_CTRL, 8'h39);
    soft_rst <= 1'b1;
    @(posedge i_sys_clk);
    soft_rst <= 1'b0;
    axi_rd(ADDR_CTRL, 8'h01);
    pwr_rst <= 1'b1;
    @(posedge i_sys_clk);
    pwr_rst <= 1'b0;
    axi_rd(ADDR_CTRL, 8'h00);
    axi_rd(ADDR_OPTION, RST_OPTION);
    repeat (6) begin
      rv = 8'($urandom);
      axi_wr(ADDR_PEN, rv);
      axi_rd(ADDR_PEN, rv & PERIPH_MASK);
    end
    s_axi_wstrb <= 4'hE;
    axi_wr(ADDR_PEN, 8'hFF);
    s_axi_wstrb <= 4'hF;
    axi_rd(ADDR_PEN, rv & PERIPH_MASK);
    $display("resets and enables done");
    axi_wr(ADDR_PEN, 8'h40);
    axi_wr(ADDR_CTRL, 8'h80);
    ev_pulse(2);
    wait_vec(16);
    chk_bit(seen, 1'b0, "vector without group enable");
    axi_wr(ADDR_CTRL, 8'hC0);
    wait_vec(16);
    chk_bit(seen, 1'b1, "no vector");
    axi_rd(ADDR_CTRL, 8'h40);
    axi_wr(ADDR_PFLAG, 8'h00);
    ret_cmd <= 1'b1;
    @(posedge i_sys_clk);
    ret_cmd <= 1'b0;
    settle();
    axi_rd(ADDR_CTRL, 8'hC0);
    axi_wr(ADDR_CTRL, 8'h20);
    ev_pulse(0);
    wait_vec(12);
    chk_bit(seen, 1'b0, "vector while disabled");
    chk_bit(wake, 1'b1, "no wake");
    axi_wr(ADDR_CTRL, 8'hA4);
    wait_vec(16);
    chk_bit(seen, 1'b1, "pending not served");
    axi_wr(ADDR_CTRL, 8'h00);
    $display("vector entry done");
    sleep_cmd <= 1'b1;
    axi_wr(ADDR_CTRL, 8'h90);
    pin <= 1'b0;
    settle();
    pin <= 1'b1;
    wait_vec(12);
    chk_bit(seen, 1'b0, "vector during sleep");
    chk_bit(wake, 1'b1, "no wake from pin");
    sleep_cmd <= 1'b0;
    wait_vec(16);
    chk_bit(seen, 1'b1, "no vector after wake");
    $display("sleep wake done");
    axi_wr(ADDR_CTRL, 8'h90);
    pin <= 1'b0;
    settle();
    pin <= 1'b1;
    wait_vec(16);
    chk_bit(seen, 1'b1, "pin latency over four cycles");
    $display("pin latency done");
    final_report();
  end
endmodule
